// ### design/cie_pkg.sv
// Constants, types and carriers shared by the instruction execute core
package cie_pkg;
	// Clock and memory pacing
	localparam int CLK_MHZ = 25;
	localparam int MEM_CYCLE_US = 5;
	localparam int SHIFT_MAX_US = 13;
	localparam int MEM_CYC = MEM_CYCLE_US * CLK_MHZ;
	localparam int SHIFT_CYC = SHIFT_MAX_US * CLK_MHZ;
	localparam int SHIFT_FULL = 36;
	localparam int SLOT_W = 9;
	localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(MEM_CYC - 1);
	localparam logic [SLOT_W-1:0] SLOT_ONE = 9'h001;

	// Word layout: bit 35 holds bit 0 (the sign)
	localparam int SGN = 35;
	localparam int OP_HI = 35;
	localparam int OP_LO = 30;
	localparam int IND_BIT = 29;
	localparam int SH_HI = 29;
	localparam int SH_LO = 27;
	localparam int X_HI = 26;
	localparam int X_LO = 18;
	localparam int HALF_LO = 18;
	localparam int Y_HI = 14;
	localparam int Y_LO = 0;

	typedef logic [35:0] cie_word_t;
	typedef logic [14:0] cie_addr_t;
	typedef logic [8:0] cie_xsel_t;

	localparam cie_word_t WORD_ZERO = 36'h0;
	localparam cie_addr_t ADDR_ZERO = 15'h0000;
	localparam cie_addr_t ADDR_ONE = 15'h0001;
	localparam cie_xsel_t X_NONE = 9'h000;
	localparam logic [5:0] PAGE_ZERO = 6'h00;
	localparam logic [2:0] D6_CLEAR = 3'h0;

	// Operation codes (two octal digits)
	localparam logic [5:0] OP_AND = 6'h02;
	localparam logic [5:0] OP_IOR = 6'h04;
	localparam logic [5:0] OP_XOR = 6'h06;
	localparam logic [5:0] OP_LIR = 6'h0C;
	localparam logic [5:0] OP_DIA = 6'h0E;
	localparam logic [5:0] OP_LAC = 6'h10;
	localparam logic [5:0] OP_LIO = 6'h12;
	localparam logic [5:0] OP_DAC = 6'h14;
	localparam logic [5:0] OP_DAP = 6'h16;
	localparam logic [5:0] OP_DIP = 6'h18;
	localparam logic [5:0] OP_DIO = 6'h1A;
	localparam logic [5:0] OP_SPX = 6'h24;
	localparam logic [5:0] OP_SNX = 6'h26;
	localparam logic [5:0] OP_SAD = 6'h28;
	localparam logic [5:0] OP_SAS = 6'h2A;
	localparam logic [5:0] OP_JMP = 6'h30;
	localparam logic [5:0] OP_JSP = 6'h32;
	localparam logic [5:0] OP_SKP = 6'h34;
	localparam logic [5:0] OP_SHL = 6'h36;
	localparam logic [5:0] OP_SHR = 6'h37;

	// Shift group third digit
	localparam logic [2:0] SHK_RAC = 3'h1;
	localparam logic [2:0] SHK_RIO = 3'h2;
	localparam logic [2:0] SHK_RCB = 3'h3;
	localparam logic [2:0] SHK_SAC = 3'h5;
	localparam logic [2:0] SHK_SIO = 3'h6;
	localparam logic [2:0] SHK_SCB = 3'h7;

	// Skip group condition bits in the address field
	localparam int SKP_SZA = 6;
	localparam int SKP_SPA = 7;
	localparam int SKP_SMA = 8;
	localparam int SKP_SPI = 10;

	typedef struct packed {
		logic req;
		logic we;
		cie_addr_t addr;
		cie_word_t wdata;
	} cie_mem_req_t;

	typedef struct packed {
		logic ack;
		cie_word_t rdata;
	} cie_mem_rsp_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_FETCH, ST_WAIT, ST_INDEX, ST_DEFER, ST_EXEC, ST_WRITE, ST_SHIFT
	} cie_state_t;

	typedef struct packed {
		cie_state_t st;
		cie_addr_t pc;
		cie_word_t primary_work_reg;
		cie_word_t io_xfer;
		cie_addr_t index_sum_unit;
		cie_word_t ir;
		cie_addr_t ea;
		cie_xsel_t xsel;
		logic xpend;
		logic ipend;
		logic done;
		logic stop_pend;
		cie_addr_t maddr;
		cie_word_t mdata;
		logic [SLOT_W-1:0] slot;
		cie_addr_t shn;
	} cie_core_t;

	localparam cie_core_t CORE_RESET = '0;
endpackage

// ### design/cie_core.sv
// Instruction execute core: fetch, address, execute and shift sequencing
`timescale 1ns/1ns
// Contract
// - Opcode from top two octal digits, bit six indirect, digits 3-5 index, 7-11 address.
// - Negative numbers are ones' complement; bit 0 sign, bits 1-35 magnitude.
// - Exclusive-or accumulates memory operand into primary register; memory untouched.
// - Code 04 inclusive-or of primary register and operand into primary register.
// - Code 20 loads operand into primary register, memory unchanged.
// - Code 24 stores primary register whole into memory at effective address.
// - Code 26 replaces memory digits 6-11 from primary register, rest kept.
// - Code 30 replaces memory digits 0-5 from primary register, rest kept.
// - Code 22 loads operand into transfer register, memory unchanged.
// - Code 32 stores transfer register into memory at effective address.
// - Code 60 loads program counter with effective address in one memory cycle.
// - Code 62 saves next address in index adder, then jumps.
// - Code 50 skips next instruction when operand and primary register differ.
// - Code 52 skips next instruction when operand and primary register match.
// - Instructions acting on the index location are never index modified.
// - Code 46 adds address to index digits, skips on negative sum.
// - Code 44 adds address to index digits, skips on positive sum.
// - Code 14 writes address into index digits 7-11, clears digit 6.
// - Code 16 writes index adder into location Y digits 7-11, clears 6.
// - Combined shifts treat transfer register as low-order extension of primary.
// - Rotate codes move bits cyclically by count in digits 7-11.
// - Shift codes scale arithmetically by count in digits 7-11.
// - Shifts of 36 steps finish within 13 us; 36 rotates restore (combined rotate of 36 swaps the two registers).
// - Code 64 tests address-selected conditions without memory; 100 is zero test.
// - Memory instructions without indexing or deferral take two memory cycles.
module cie_core (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire cie_pkg::cie_addr_t start_addr,
	input wire logic stop,
	output cie_pkg::cie_mem_req_t mem_o,
	input wire cie_pkg::cie_mem_rsp_t mem_i,
	output logic running,
	output cie_pkg::cie_addr_t pc_o,
	output cie_pkg::cie_word_t primary_work_reg_o,
	output cie_pkg::cie_word_t io_xfer_o,
	output cie_pkg::cie_addr_t index_sum_unit_o
);
	import cie_pkg::*;

	cie_core_t s_reg;
	cie_core_t s_next;
	logic [5:0] op;
	logic [5:0] rd_op;
	logic [15:0] icnt_reg;

	assign op = s_reg.ir[OP_HI:OP_LO];
	assign rd_op = mem_i.rdata[OP_HI:OP_LO];

	// Ones' complement 15-bit add with end-around carry
	function automatic cie_addr_t oc_add(cie_addr_t a, cie_addr_t b);
		logic [15:0] t;
		t = {1'b0, a} + {1'b0, b};
		return t[Y_HI:Y_LO] + cie_addr_t'(t[Y_HI+1]);
	endfunction

	// Codes that may be indexed or deferred
	function automatic logic is_idx(logic [5:0] o);
		return o inside {OP_AND, OP_IOR, OP_XOR, OP_LAC, OP_LIO, OP_DAC, OP_DAP,
			OP_DIP, OP_DIO, OP_SAD, OP_SAS, OP_JMP, OP_JSP};
	endfunction

	// Codes that address the index location itself
	function automatic logic is_xop(logic [5:0] o);
		return o inside {OP_LIR, OP_SPX, OP_SNX};
	endfunction

	// Codes that take an operand memory cycle
	function automatic logic is_mem(logic [5:0] o);
		return (is_idx(o) && !(o inside {OP_JMP, OP_JSP})) || is_xop(o) || o == OP_DIA;
	endfunction

	// Codes that write their memory operand back
	function automatic logic is_wr(logic [5:0] o);
		return o inside {OP_DAC, OP_DAP, OP_DIP, OP_DIO, OP_LIR, OP_DIA, OP_SPX, OP_SNX};
	endfunction

	// One rotate step of a single register
	function automatic cie_word_t rot1(cie_word_t w, logic left);
		return left ? {w[SGN-1:0], w[SGN]} : {w[0], w[SGN:1]};
	endfunction

	// One arithmetic step; sign kept and copied in, as ones' complement needs
	function automatic cie_word_t ash1(cie_word_t w, logic left);
		return left ? {w[SGN], w[SGN-2:0], w[SGN]} : {w[SGN], w[SGN], w[SGN-1:1]};
	endfunction

	// One step of the shift group; unused third digits leave both untouched
	function automatic logic [71:0] sh_step(cie_word_t a, cie_word_t q, logic [2:0] k, logic left);
		cie_word_t na;
		cie_word_t nq;
		na = a;
		nq = q;
		case (k)
			SHK_RAC: na = rot1(a, left);
			SHK_RIO: nq = rot1(q, left);
			SHK_SAC: na = ash1(a, left);
			SHK_SIO: nq = ash1(q, left);
			SHK_RCB: begin
				{na, nq} = left ? {a[SGN-1:0], q, a[SGN]} : {q[0], a, q[SGN:1]};
			end
			SHK_SCB: begin
				// Transfer register is pure magnitude below the sign
				if (left) begin
					na = {a[SGN], a[SGN-2:0], q[SGN]};
					nq = {q[SGN-1:0], a[SGN]};
				end else begin
					na = {a[SGN], a[SGN], a[SGN-1:1]};
					nq = {a[0], q[SGN:1]};
				end
			end
			default: ;
		endcase
		return {na, nq};
	endfunction

	// Sequencer: every memory slot lasts one full memory cycle
	always_comb begin
		cie_addr_t sum;
		cie_word_t rd;
		logic fin;
		logic cond;
		sum = ADDR_ZERO;
		rd = mem_i.rdata;
		fin = 1'b0;
		cond = 1'b0;
		s_next = s_reg;
		s_next.stop_pend = s_reg.stop_pend | stop;
		if (s_reg.slot != SLOT_LAST) begin
			s_next.slot = s_reg.slot + SLOT_ONE;
		end
		case (s_reg.st)
			ST_IDLE: begin
				if (start) begin
					s_next.pc = start_addr;
					s_next.maddr = start_addr;
					// A stop in the same cycle as start still wins
					s_next.stop_pend = stop;
					s_next.slot = '0;
					s_next.st = ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (mem_i.ack) begin
					s_next.ir = rd;
					s_next.pc = s_reg.pc + ADDR_ONE;
					s_next.ea = rd[Y_HI:Y_LO];
					s_next.xsel = rd[X_HI:X_LO];
					// Index location codes never see index modification
					s_next.xpend = is_idx(rd_op) && rd[X_HI:X_LO] != X_NONE;
					s_next.ipend = is_idx(rd_op) && rd[IND_BIT];
					s_next.done = 1'b0;
					s_next.st = ST_WAIT;
				end
			end
			ST_INDEX: begin
				if (mem_i.ack) begin
					s_next.ea = oc_add(s_reg.ea, rd[Y_HI:Y_LO]);
					s_next.xpend = 1'b0;
					s_next.st = ST_WAIT;
				end
			end
			ST_DEFER: begin
				// A deferred word may itself be indexed and deferred again
				if (mem_i.ack) begin
					s_next.ea = rd[Y_HI:Y_LO];
					s_next.xsel = rd[X_HI:X_LO];
					s_next.xpend = rd[X_HI:X_LO] != X_NONE;
					s_next.ipend = rd[IND_BIT];
					s_next.st = ST_WAIT;
				end
			end
			ST_EXEC: begin
				if (mem_i.ack) begin
					s_next.mdata = rd;
					case (op)
						OP_AND: s_next.primary_work_reg = s_reg.primary_work_reg & rd;
						OP_IOR: s_next.primary_work_reg = s_reg.primary_work_reg | rd;
						OP_XOR: s_next.primary_work_reg = s_reg.primary_work_reg ^ rd;
						OP_LAC: s_next.primary_work_reg = rd;
						OP_LIO: s_next.io_xfer = rd;
						OP_DAC: s_next.mdata = s_reg.primary_work_reg;
						OP_DAP: s_next.mdata = {rd[SGN:HALF_LO], s_reg.primary_work_reg[HALF_LO-1:0]};
						OP_DIP: s_next.mdata = {s_reg.primary_work_reg[SGN:HALF_LO], rd[HALF_LO-1:0]};
						OP_DIO: s_next.mdata = s_reg.io_xfer;
						OP_SAD: cond = rd != s_reg.primary_work_reg;
						OP_SAS: cond = rd == s_reg.primary_work_reg;
						OP_SPX, OP_SNX: begin
							sum = oc_add(rd[Y_HI:Y_LO], s_reg.ir[Y_HI:Y_LO]);
							s_next.index_sum_unit = sum;
							s_next.mdata = {rd[SGN:HALF_LO], D6_CLEAR, sum};
							// Minus zero counts as negative
							cond = sum[Y_HI] == (op == OP_SNX);
						end
						OP_LIR: s_next.mdata = {rd[SGN:HALF_LO], D6_CLEAR, s_reg.ir[Y_HI:Y_LO]};
						OP_DIA: s_next.mdata = {rd[SGN:HALF_LO], D6_CLEAR, s_reg.index_sum_unit};
						default: ;
					endcase
					if (cond) begin
						s_next.pc = s_reg.pc + ADDR_ONE;
					end
					s_next.done = 1'b1;
					s_next.st = is_wr(op) ? ST_WRITE : ST_WAIT;
				end
			end
			ST_WRITE: begin
				if (mem_i.ack) begin
					s_next.st = ST_WAIT;
				end
			end
			ST_SHIFT: begin
				// One step a clock keeps 36 steps far inside the limit
				if (s_reg.shn == ADDR_ZERO) begin
					fin = 1'b1;
				end else begin
					{s_next.primary_work_reg, s_next.io_xfer} = sh_step(s_reg.primary_work_reg,
						s_reg.io_xfer, s_reg.ir[SH_HI:SH_LO], op == OP_SHL);
					s_next.shn = s_reg.shn - ADDR_ONE;
				end
			end
			ST_WAIT: begin
				if (s_reg.slot == SLOT_LAST) begin
					s_next.slot = '0;
					if (s_reg.done) begin
						fin = 1'b1;
					end else if (s_reg.xpend) begin
						s_next.st = ST_INDEX;
						s_next.maddr = {PAGE_ZERO, s_reg.xsel};
					end else if (s_reg.ipend) begin
						s_next.st = ST_DEFER;
						s_next.maddr = s_reg.ea;
					end else if (is_mem(op)) begin
						s_next.st = ST_EXEC;
						s_next.maddr = is_xop(op) ? {PAGE_ZERO, s_reg.xsel} : s_reg.ea;
					end else begin
						case (op)
							OP_JMP: s_next.pc = s_reg.ea;
							OP_JSP: begin
								s_next.index_sum_unit = s_reg.pc;
								s_next.pc = s_reg.ea;
							end
							OP_SKP: begin
								// Selected conditions combine as inclusive or
								cond = (s_reg.ir[SKP_SZA] && s_reg.primary_work_reg == WORD_ZERO) ||
									(s_reg.ir[SKP_SPA] && !s_reg.primary_work_reg[SGN]) ||
									(s_reg.ir[SKP_SMA] && s_reg.primary_work_reg[SGN]) ||
									(s_reg.ir[SKP_SPI] && !s_reg.io_xfer[SGN]);
								if (cond) begin
									s_next.pc = s_reg.pc + ADDR_ONE;
								end
							end
							default: ;
						endcase
						if (op == OP_SHL || op == OP_SHR) begin
							s_next.shn = s_reg.ir[Y_HI:Y_LO];
							s_next.st = ST_SHIFT;
						end else begin
							fin = 1'b1;
						end
					end
				end
			end
			default: s_next.st = ST_IDLE;
		endcase
		// Instruction end: stop only between instructions
		if (fin) begin
			s_next.done = 1'b0;
			s_next.slot = '0;
			s_next.maddr = s_next.pc;
			s_next.st = s_next.stop_pend ? ST_IDLE : ST_FETCH;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_reg <= CORE_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// Memory request: strobes from state, address and data from flops
	always_comb begin
		mem_o.req = s_reg.st inside {ST_FETCH, ST_INDEX, ST_DEFER, ST_EXEC, ST_WRITE};
		mem_o.we = s_reg.st == ST_WRITE;
		mem_o.addr = s_reg.maddr;
		mem_o.wdata = s_reg.mdata;
	end

	assign running = s_reg.st != ST_IDLE;
	assign pc_o = s_reg.pc;
	assign primary_work_reg_o = s_reg.primary_work_reg;
	assign io_xfer_o = s_reg.io_xfer;
	assign index_sum_unit_o = s_reg.index_sum_unit;

	// Cycles since the current instruction was fetched, for timing checks
	always_ff @(posedge clk) begin
		if (!rst_n || (s_next.st == ST_FETCH && s_reg.st != ST_FETCH)) begin
			icnt_reg <= 16'h0000;
		end else if (icnt_reg != 16'hFFFF) begin
			icnt_reg <= icnt_reg + 16'h0001;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	xor_result_a: assert property (
		(s_reg.st == ST_EXEC && mem_i.ack && op == OP_XOR) |=>
		s_reg.primary_work_reg == ($past(s_reg.primary_work_reg) ^ $past(mem_i.rdata)))
		else $error("xor result wrong");
	ior_result_a: assert property (
		(s_reg.st == ST_EXEC && mem_i.ack && op == OP_IOR) |=>
		s_reg.primary_work_reg == ($past(s_reg.primary_work_reg) | $past(mem_i.rdata)))
		else $error("ior result wrong");
	lac_load_a: assert property (
		(s_reg.st == ST_EXEC && mem_i.ack && op == OP_LAC) |=>
		s_reg.primary_work_reg == $past(mem_i.rdata) && s_reg.st == ST_WAIT)
		else $error("load primary wrong");
	dac_store_a: assert property (
		(s_reg.st == ST_WRITE && op == OP_DAC) |-> mem_o.we && mem_o.wdata == s_reg.primary_work_reg)
		else $error("store primary wrong");
	dap_merge_a: assert property (
		(s_reg.st == ST_WRITE && op == OP_DAP) |->
		mem_o.wdata[HALF_LO-1:0] == s_reg.primary_work_reg[HALF_LO-1:0])
		else $error("address part merge wrong");
	jmp_target_a: assert property (
		(s_reg.st == ST_WAIT && s_reg.slot == SLOT_LAST && op == OP_JMP && !s_reg.done &&
		!s_reg.xpend && !s_reg.ipend) |=> s_reg.pc == $past(s_reg.ea) && s_reg.st != ST_EXEC)
		else $error("jump target wrong");
	sad_skip_a: assert property (
		(s_reg.st == ST_EXEC && mem_i.ack && op == OP_SAD) |=>
		s_reg.pc == $past(s_reg.pc) + cie_addr_t'($past(mem_i.rdata) != $past(s_reg.primary_work_reg)))
		else $error("differ skip wrong");
	xop_noindex_a: assert property (
		(s_reg.st == ST_FETCH && mem_i.ack && is_xop(rd_op)) |=> !s_reg.xpend ##1 s_reg.st == ST_WAIT)
		else $error("index location code was indexed");
	shift_time_a: assert property (
		(s_reg.st == ST_SHIFT && s_reg.shn == ADDR_ZERO && s_reg.ir[Y_HI:Y_LO] <= SHIFT_FULL) |->
		icnt_reg < SHIFT_CYC)
		else $error("shift too slow");

	lac_seen_c: cover property (s_reg.st == ST_EXEC && mem_i.ack && op == OP_LAC);
	shift_done_c: cover property (s_reg.st == ST_SHIFT && s_reg.shn == ADDR_ZERO);
	skip_taken_c: cover property (s_reg.st == ST_EXEC && mem_i.ack && op == OP_SAS &&
		mem_i.rdata == s_reg.primary_work_reg);
endmodule

// ### testbench/cie_mem_model.sv
// Behavioural core memory answering the execute core
`timescale 1ns/1ns
module cie_mem_model (
	input wire logic clk,
	input wire cie_pkg::cie_mem_req_t mem_o,
	output cie_pkg::cie_mem_rsp_t mem_i,
	input wire logic [1:0] dly
);
	import cie_pkg::*;
	cie_word_t mem [0:4095];
	logic [1:0] cnt;
	initial begin
		mem_i = '0;
		cnt = 2'h0;
	end
	// Ack after dly falling edges; data shows inverted junk once released
	always @(negedge clk) begin
		if (mem_i.ack) begin
			mem_i.ack <= 1'b0;
			mem_i.rdata <= ~mem_i.rdata;
			cnt <= 2'h0;
		end else if (mem_o.req && cnt >= dly) begin
			mem_i.ack <= 1'b1;
			mem_i.rdata <= mem[mem_o.addr[11:0]];
		end else if (mem_o.req) begin
			cnt <= cnt + 2'h1;
		end
	end
	// Write lands on the edge that completes the access
	always @(posedge clk) begin
		if (mem_o.req && mem_o.we && mem_i.ack) begin
			mem[mem_o.addr[11:0]] <= mem_o.wdata;
		end
	end
endmodule

// ### testbench/tb.sv
// Self-checking bench for the instruction execute core
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH %0t compare got %h expected %h", $time, g, e); end end
module tb;
	import cie_pkg::*;
	localparam cie_word_t POISON = 36'hAAAAAAAAA;
	localparam logic [5:0] SK_OP [23] = '{OP_LAC, OP_SAS, OP_DAC, OP_SAD, OP_DAC, OP_SAD, OP_DAC, OP_SKP,
		OP_DAC, OP_AND, OP_SKP, OP_DAC, OP_SAS, OP_DAC, OP_LAC, OP_LIO, OP_SKP, OP_DAC, OP_SKP, OP_DAC,
		OP_SKP, OP_DAC, OP_JMP};
	localparam logic [11:0] SK_Y [23] = '{12'h130, 12'h130, 12'h140, 12'h130, 12'h141, 12'h131, 12'h142,
		12'h040, 12'h143, 12'h131, 12'h040, 12'h144, 12'h131, 12'h145, 12'h130, 12'h131, 12'h080, 12'h146,
		12'h100, 12'h147, 12'h400, 12'h148, 12'h056};
	localparam logic [2:0] SH_KIND [6] = '{SHK_RAC, SHK_RIO, SHK_RCB, SHK_SAC, SHK_SIO, SHK_SCB};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic start = 1'b0;
	cie_addr_t start_addr = ADDR_ZERO;
	logic stop = 1'b0;
	logic [1:0] dly = 2'h0;
	cie_mem_req_t mem_o;
	cie_mem_rsp_t mem_i;
	logic running;
	cie_addr_t pc_o;
	cie_word_t primary_work_reg_o;
	cie_word_t io_xfer_o;
	cie_addr_t index_sum_unit_o;
	int miscompares = 0;
	int n_tests = 0;
	int seed = 32'hEA37A132;
	int gaps [$];
	int cyc = 0;
	int last_fetch = 0;
	int n_halt = 0;
	cie_addr_t halt_at = ADDR_ZERO;
	cie_word_t a, b, c, d, w, v;
	cie_word_t e [9];

	cie_core cie_core_i (.clk(clk), .rst_n(rst_n), .start(start), .start_addr(start_addr), .stop(stop),
		.mem_o(mem_o), .mem_i(mem_i), .running(running), .pc_o(pc_o),
		.primary_work_reg_o(primary_work_reg_o), .io_xfer_o(io_xfer_o), .index_sum_unit_o(index_sum_unit_o));
	cie_mem_model cie_mem_model_i (.clk(clk), .mem_o(mem_o), .mem_i(mem_i), .dly(dly));

	always #20 clk = ~clk;

	// Fetch spacing and halt-loop detection; operand addresses never equal pc
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (mem_o.req && !mem_o.we && mem_i.ack && mem_o.addr == pc_o) begin
			gaps.push_back(cyc - last_fetch);
			last_fetch = cyc;
			if (mem_o.addr == halt_at) n_halt++;
		end
	end

	function automatic cie_word_t ins(logic [5:0] op, logic [2:0] k, cie_xsel_t x, cie_addr_t y);
		return {op, k, x, D6_CLEAR, y};
	endfunction

	function automatic cie_word_t rnd();
		return cie_word_t'({$random(seed), $random(seed)});
	endfunction

	// Fifteen-bit add with end-around carry
	function automatic cie_addr_t oc15(cie_addr_t x, cie_addr_t y);
		logic [15:0] s;
		s = {1'b0, x} + {1'b0, y};
		return s[14:0] + {14'h0, s[15]};
	endfunction

	// Step-by-step reference for the rotate and shift group
	function automatic logic [71:0] shx(logic [2:0] kd, logic right, cie_word_t ac, cie_word_t io, int n);
		logic [71:0] r;
		r = {ac, io};
		repeat (n) begin
			case (kd)
				SHK_RAC: r[71:36] = right ? {r[36], r[71:37]} : {r[70:36], r[71]};
				SHK_RIO: r[35:0] = right ? {r[0], r[35:1]} : {r[34:0], r[35]};
				SHK_RCB: r = right ? {r[0], r[71:1]} : {r[70:0], r[71]};
				SHK_SAC: r[71:36] = right ? {r[71], r[71:37]} : {r[71], r[69:36], r[71]};
				SHK_SIO: r[35:0] = right ? {r[35], r[35:1]} : {r[35], r[33:0], r[35]};
				default: r = right ? {r[71], r[71:1]} : {r[71], r[69:0], r[71]};
			endcase
		end
		return r;
	endfunction

	task automatic put(input cie_addr_t ad, input cie_word_t wd);
		cie_mem_model_i.mem[ad[11:0]] = wd;
	endtask

	function automatic cie_word_t rd(cie_addr_t ad);
		return cie_mem_model_i.mem[ad[11:0]];
	endfunction

	task automatic results();
		$display("Counts: %0d compares, %0d mismatches", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Start at s, let the self-jump at h come round twice, then stop
	task automatic run(input cie_addr_t s, input cie_addr_t h);
		int i;
		halt_at = h;
		n_halt = 0;
		gaps.delete();
		last_fetch = cyc;
		start_addr = s;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		for (i = 0; i < 20000 && n_halt < 2; i++) @(negedge clk);
		stop = 1'b1;
		@(negedge clk);
		stop = 1'b0;
		for (i = 0; i < 2000 && running !== 1'b0; i++) @(negedge clk);
		if (n_halt < 2 || running !== 1'b0) begin
			miscompares++;
			$display("MISMATCH %0t run hung", $time);
			results();
		end
	endtask

	initial begin
		int i;
		int k;
		int n;
		for (i = 0; i < 4096; i++) cie_mem_model_i.mem[i] = POISON;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		// Logic, load and store chain with prompt memory so timing is exact
		a = rnd();
		b = rnd();
		c = rnd();
		d = rnd();
		w = rnd();
		v = rnd();
		put(15'h0100, a);
		put(15'h0101, b);
		put(15'h0102, c);
		put(15'h0103, d);
		put(15'h0111, w);
		put(15'h0112, v);
		put(15'h0040, ins(OP_LAC, 3'h0, X_NONE, 15'h0100));
		put(15'h0041, ins(OP_XOR, 3'h0, X_NONE, 15'h0101));
		put(15'h0042, ins(OP_IOR, 3'h0, X_NONE, 15'h0102));
		put(15'h0043, ins(OP_DAC, 3'h0, X_NONE, 15'h0110));
		put(15'h0044, ins(OP_DAP, 3'h0, X_NONE, 15'h0111));
		put(15'h0045, ins(OP_DIP, 3'h0, X_NONE, 15'h0112));
		put(15'h0046, ins(OP_LIO, 3'h0, X_NONE, 15'h0103));
		put(15'h0047, ins(OP_DIO, 3'h0, X_NONE, 15'h0113));
		put(15'h0048, ins(6'h3E, 3'h0, X_NONE, ADDR_ZERO));
		put(15'h0049, ins(OP_JMP, 3'h0, X_NONE, 15'h0049));
		run(15'h0040, 15'h0049);
		c = (a ^ b) | c;
		`CHK(primary_work_reg_o, c)
		`CHK(rd(15'h0100), a)
		`CHK(rd(15'h0110), c)
		`CHK(rd(15'h0111), {w[35:18], c[17:0]})
		`CHK(rd(15'h0112), {c[35:18], v[17:0]})
		`CHK(io_xfer_o, d)
		`CHK(rd(15'h0113), d)
		for (i = 0; i < 10; i++) `CHK(gaps[i + 1], (i < 8) ? 2 * MEM_CYC : MEM_CYC)
		$display("test logic and store done");
		// Index step, load, adder save and deposit with a random memory delay of 0 to 3
		dly = 2'($random(seed) & 3);
		w = rnd();
		b = rnd();
		v = rnd();
		put(15'h0005, w);
		// Pointer word for the indexed, deferred load below
		put(15'h0210, ins(6'h00, 3'h0, X_NONE, 15'h0211));
		put(15'h0211, b);
		put(15'h0120, v);
		put(15'h0040, ins(OP_LIR, 3'h0, 9'h005, 15'h0010));
		put(15'h0041, ins(OP_LAC, 3'h4, 9'h005, 15'h0200));
		put(15'h0042, ins(OP_SPX, 3'h0, 9'h005, 15'h0003));
		put(15'h0043, ins(OP_DAC, 3'h0, X_NONE, 15'h0121));
		put(15'h0044, ins(OP_SNX, 3'h0, 9'h005, 15'h7FFC));
		put(15'h0045, ins(OP_DAC, 3'h0, X_NONE, 15'h0122));
		put(15'h0046, ins(OP_JSP, 3'h0, X_NONE, 15'h0050));
		put(15'h0050, ins(OP_DIA, 3'h0, 9'h007, 15'h0120));
		put(15'h0051, ins(OP_JMP, 3'h0, X_NONE, 15'h0051));
		run(15'h0040, 15'h0051);
		`CHK(rd(15'h0005), {w[35:18], D6_CLEAR, oc15(oc15(15'h0010, 15'h0003), 15'h7FFC)})
		`CHK(rd(15'h0121), POISON)
		`CHK(rd(15'h0122), b)
		`CHK(index_sum_unit_o, 15'h0047)
		`CHK(rd(15'h0120), {v[35:18], D6_CLEAR, 15'h0047})
		`CHK(pc_o, 15'h0051)
		$display("test index done");
		// Compare and condition skips, taken and not taken
		dly = 2'($random(seed) & 3);
		a = rnd() | 36'h000000001;
		put(15'h0130, a);
		put(15'h0131, ~a);
		put(15'h0132, WORD_ZERO);
		for (k = 0; k < 23; k++) put(15'(15'h0040 + k), ins(SK_OP[k], 3'h0, X_NONE, 15'(SK_Y[k])));
		run(15'h0040, 15'h0056);
		// Sign conditions: transfer register holds the complement of the primary register
		e = '{POISON, a, POISON, a, POISON, WORD_ZERO, a[35] ? a : POISON, a[35] ? POISON : a,
			a[35] ? POISON : a};
		for (k = 0; k < 9; k++) `CHK(rd(15'(15'h0140 + k)), e[k])
		$display("test skips done");
		// Every rotate and shift code, first one a full 36-step rotate
		for (k = 0; k < 12; k++) begin
			dly = 2'($random(seed) & 3);
			a = rnd();
			b = rnd();
			n = (k == 0) ? SHIFT_FULL : int'($unsigned($random(seed)) % 37);
			put(15'h0150, a);
			put(15'h0151, b);
			put(15'h0040, ins(OP_LAC, 3'h0, X_NONE, 15'h0150));
			put(15'h0041, ins(OP_LIO, 3'h0, X_NONE, 15'h0151));
			put(15'h0042, ins(k[0] ? OP_SHR : OP_SHL, SH_KIND[k >> 1], X_NONE, 15'(n)));
			put(15'h0043, ins(OP_JMP, 3'h0, X_NONE, 15'h0043));
			run(15'h0040, 15'h0043);
			{w, v} = shx(SH_KIND[k >> 1], k[0], a, b, n);
			`CHK({primary_work_reg_o, io_xfer_o}, {w, v})
			`CHK(gaps[3] <= SHIFT_CYC, 1'b1)
		end
		$display("test rotate and shift done");
		results();
	end
endmodule
